// ===== hw/audio_bridge_regs.svh
// Register offsets, field positions, reset values and timing counts of the audio serial bridge.
`ifndef AUDIO_BRIDGE_REGS_SVH
`define AUDIO_BRIDGE_REGS_SVH

// Byte offsets of the registers on the bus.
`define AUD_CTRL_OFS 6'h00
`define AUD_STATUS_OFS 6'h04
`define AUD_MARKS_OFS 6'h08
`define AUD_PKTS_OFS 6'h0c
`define AUD_STEP_OFS 6'h10
`define AUD_INC_OFS 6'h14
`define AUD_TXDATA_OFS 6'h18
`define AUD_RXDATA_OFS 6'h1c
`define AUD_PKTSEL_OFS 6'h20
`define AUD_SOFMEAS_OFS 6'h24

// Control register fields.
`define AUD_CTRL_OUT_EN 0
`define AUD_CTRL_IN_EN 1
`define AUD_CTRL_FMT 2
`define AUD_CTRL_SIZE 4
`define AUD_CTRL_STEREO 6
`define AUD_CTRL_JACK_EN 7
`define AUD_CTRL_MODE 8
`define AUD_CTRL_FAST 10
`define AUD_CTRL_RATE 11

// Status register fields.
`define AUD_STAT_IN_LVL 0
`define AUD_STAT_OUT_LVL 8
`define AUD_STAT_MIC 16
`define AUD_STAT_JACK_EVT 17

// Watermark register fields.
`define AUD_MARK_IN_LOW 0
`define AUD_MARK_IN_HIGH 8
`define AUD_MARK_OUT_LOW 16
`define AUD_MARK_OUT_HIGH 24

// Packet size register fields.
`define AUD_PKT_SMALL 0
`define AUD_PKT_NORMAL 8
`define AUD_PKT_LARGE 16

// Reset values.
`define AUD_CTRL_RST 32'h0000_41c3
`define AUD_MARKS_RST 32'h0c04_0c04
`define AUD_PKTS_RST 32'h00c4_c0bc
`define AUD_STEP_RST 16'h0100

// Timing.
`define AUD_CLK_HZ 25000000
`define AUD_CLK_PERIOD_NS 40
`define AUD_SOF_PERIOD_NS 1000000
`define AUD_SOF_CYCLES (`AUD_SOF_PERIOD_NS / `AUD_CLK_PERIOD_NS)
`define AUD_SOF_WINDOW 16
`define AUD_FIFO_DEPTH 16

`endif

// ===== hw/audio_bridge_pkg.sv
// Types shared by the audio serial bridge modules.
package audio_bridge_pkg;
  // Alignment of data inside a word-select slot.
  typedef enum logic [1:0] {FMT_I2S, FMT_LEFT, FMT_RIGHT} audio_format_e;
  // How the sampling clock is steered.
  typedef enum logic [1:0] {MODE_FIXED, MODE_ADAPTIVE, MODE_SOF_LOCKED} clock_mode_e;
  // Bus slave answer sequence.
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_e;
endpackage

// ===== hw/audio_fifo.sv
// Show-ahead sample FIFO, 32 bits wide and 16 deep.
`timescale 1ns/1ps
`include "audio_bridge_regs.svh"
module audio_fifo
  import audio_bridge_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Write side.
  input wire logic push,
  input wire logic [31:0] push_data,
  // Read side.
  input wire logic pop,
  output logic [31:0] head,
  // Fill state.
  output logic full,
  output logic empty,
  output logic [4:0] level
);
  // Storage and pointers as one state word.
  typedef struct packed {
    logic [`AUD_FIFO_DEPTH-1:0][31:0] mem;
    logic [3:0] rptr;
    logic [3:0] wptr;
    logic [4:0] level;
  } fifo_s;
  fifo_s st_q, st_d;
  logic do_push, do_pop;

  assign full = (st_q.level == 5'h10);
  assign empty = (st_q.level == 5'h00);
  assign level = st_q.level;
  assign head = st_q.mem[st_q.rptr];
  // A push into a full FIFO and a pop from an empty one are dropped.
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  // Pointer and level update.
  always_comb begin
    st_d = st_q;
    if (do_push) begin
      st_d.mem[st_q.wptr] = push_data;
      st_d.wptr = st_q.wptr + 4'h1;
    end
    if (do_pop) begin
      st_d.rptr = st_q.rptr + 4'h1;
    end
    st_d.level = st_q.level + {4'h0, do_push} - {4'h0, do_pop};
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // The fill never passes the depth and rises by one on every accepted push made without a pop.
  property p_fifo_level;
    @(posedge clk) disable iff (rst)
      (push && !full && !pop) |=> (level == $past(level) + 5'h01) && (level <= 5'h10);
  endproperty
  a_fifo_level: assert property (p_fifo_level) else $error("fifo level wrong after push");
endmodule

// ===== hw/sample_clock_nco.sv
// Phase accumulator that ticks at twice the serial bit rate.
`timescale 1ns/1ps
module sample_clock_nco (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Phase step per clock and run enable.
  input wire logic [31:0] inc,
  input wire logic run,
  // One-cycle tick at each carry.
  output logic tick
);
  // Accumulator and registered tick.
  typedef struct packed {
    logic [31:0] acc;
    logic tick;
  } nco_s;
  nco_s st_q, st_d;
  logic [32:0] sum;

  assign tick = st_q.tick;

  // Add the step; a carry out is one half bit period.
  always_comb begin
    st_d = st_q;
    sum = {1'b0, st_q.acc} + {1'b0, inc};
    if (run) begin
      st_d.acc = sum[31:0];
      st_d.tick = sum[32];
    end else begin
      st_d.acc = '0;
      st_d.tick = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // A stopped accumulator never ticks.
  property p_nco_idle;
    @(posedge clk) disable iff (rst)
      !run |=> !tick;
  endproperty
  a_nco_idle: assert property (p_nco_idle) else $error("tick while stopped");
endmodule

// ===== hw/usb_audio_serial_bridge.sv
// Audio serial bridge: serial codec link, sample FIFOs, clock steering and register slave.
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "audio_bridge_regs.svh"
module usb_audio_serial_bridge
  import audio_bridge_pkg::*;
#(
  // Clock cycles between frame start markers.
  parameter int SOF_NOMINAL_CYCLES = `AUD_SOF_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM register slave.
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Frame start marker from the USB side, one-cycle pulse.
  input wire logic sof,
  // Packet size chosen for the next input packet.
  output logic [7:0] in_packet_bytes,
  output logic in_packet_valid,
  // Serial codec link.
  output logic audio_master_clock,
  output logic audio_bit_clock,
  output logic audio_word_select,
  output logic audio_serial_out,
  output logic audio_serial_out_oe,
  input wire logic audio_serial_in,
  // Plug detect and its report.
  input wire logic mic_plug_detect,
  output logic jack_report,
  // Speed select for the codec control link.
  output logic ctl_link_fast
);
  // Every register of the bridge except those inside the two FIFOs and the NCO.
  typedef struct packed {
    bus_state_e bus;
    logic waitreq;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] marks;
    logic [31:0] pkts;
    logic [15:0] step;
    logic [31:0] inc;
    logic mclk;
    logic sck;
    logic ws;
    logic [5:0] bitcnt;
    logic sdo;
    logic sdo_oe;
    logic [31:0] rxbuf;
    logic [7:0] pkt_bytes;
    logic pkt_valid;
    logic [19:0] sof_cnt;
    logic [3:0] sof_num;
    logic [23:0] sof_sum;
    logic [23:0] sof_meas;
    logic jack_evt;
    logic mic_prev;
    logic jack_rep;
    logic fast;
  } bridge_s;
  bridge_s st_q, st_d;

  // FIFO hookups.
  logic tx_push, tx_pop, tx_full, tx_empty;
  logic rx_push, rx_pop, rx_full, rx_empty;
  logic [31:0] tx_head, rx_head, rx_word;
  logic [4:0] tx_level, rx_level;
  // Serial timing.
  logic tick, running;
  // Decoded configuration.
  logic out_en, in_en, stereo;
  logic [5:0] width, offset;
  clock_mode_e mode;
  logic [31:0] base_inc;
  logic [23:0] window_nominal;

  // Phase step for each rate code; the NCO ticks at 128 times fs.
  function automatic logic [31:0] rate_inc(input logic [3:0] code);
    case (code)
      4'h0: return 32'((64'd8000 << 39) / 64'(`AUD_CLK_HZ));
      4'h1: return 32'((64'd11025 << 39) / 64'(`AUD_CLK_HZ));
      4'h2: return 32'((64'd12000 << 39) / 64'(`AUD_CLK_HZ));
      4'h3: return 32'((64'd16000 << 39) / 64'(`AUD_CLK_HZ));
      4'h4: return 32'((64'd22050 << 39) / 64'(`AUD_CLK_HZ));
      4'h5: return 32'((64'd24000 << 39) / 64'(`AUD_CLK_HZ));
      4'h6: return 32'((64'd32000 << 39) / 64'(`AUD_CLK_HZ));
      4'h7: return 32'((64'd44100 << 39) / 64'(`AUD_CLK_HZ));
      default: return 32'((64'd48000 << 39) / 64'(`AUD_CLK_HZ));
    endcase
  endfunction

  // Byte-lane merge of a bus write into a register.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Size code to bits per sample.
  function automatic logic [5:0] sample_width(input logic [1:0] code);
    case (code)
      2'h1: return 6'h18;
      2'h2: return 6'h20;
      default: return 6'h10;
    endcase
  endfunction

  // Sample FIFO from the host toward the codec.
  audio_fifo u_out_fifo (
    .clk(clk), .rst(rst), .push(tx_push), .push_data(avs_writedata), .pop(tx_pop),
    .head(tx_head), .full(tx_full), .empty(tx_empty), .level(tx_level)
  );
  // Sample FIFO from the codec toward the host.
  audio_fifo u_in_fifo (
    .clk(clk), .rst(rst), .push(rx_push), .push_data(rx_word), .pop(rx_pop),
    .head(rx_head), .full(rx_full), .empty(rx_empty), .level(rx_level)
  );
  // Sampling clock generator.
  sample_clock_nco u_nco (
    .clk(clk), .rst(rst), .inc(st_q.inc), .run(running), .tick(tick)
  );

  // Configuration decode.
  assign out_en = st_q.ctrl[`AUD_CTRL_OUT_EN];
  assign in_en = st_q.ctrl[`AUD_CTRL_IN_EN];
  assign running = out_en || in_en;
  assign stereo = st_q.ctrl[`AUD_CTRL_STEREO];
  assign width = sample_width(st_q.ctrl[`AUD_CTRL_SIZE +: 2]);
  assign mode = clock_mode_e'(st_q.ctrl[`AUD_CTRL_MODE +: 2]);
  assign base_inc = rate_inc(st_q.ctrl[`AUD_CTRL_RATE +: 4]);
  assign window_nominal = 24'(SOF_NOMINAL_CYCLES * `AUD_SOF_WINDOW);
  // Data starts one bit after the slot edge, at it, or flush to its end.
  always_comb begin
    case (audio_format_e'(st_q.ctrl[`AUD_CTRL_FMT +: 2]))
      FMT_I2S: offset = 6'h01;
      FMT_RIGHT: offset = 6'h20 - width;
      default: offset = 6'h00;
    endcase
  end

  // Next-state logic of the whole bridge.
  always_comb begin
    logic [5:0] nb;
    logic [5:0] rel;
    logic [31:0] aligned;
    logic [31:0] buf_new;
    st_d = st_q;
    nb = st_q.bitcnt + 6'h01;
    rel = 6'h00;
    aligned = tx_head << (6'h20 - width);
    buf_new = st_q.rxbuf;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_word = '0;
    st_d.pkt_valid = 1'b0;

    // Serial framing: each tick is one half bit period.
    if (!running) begin
      st_d.mclk = 1'b0;
      st_d.sck = 1'b0;
      st_d.ws = 1'b0;
      st_d.bitcnt = 6'h00;
      st_d.sdo = 1'b0;
    end else if (tick) begin
      st_d.mclk = ~st_q.mclk;
      st_d.sck = ~st_q.sck;
      if (st_q.sck) begin
        // Falling bit clock: advance and present the next output bit.
        st_d.bitcnt = nb;
        st_d.ws = nb[5];
        rel = nb - offset;
        st_d.sdo = 1'b0;
        if (out_en && ({1'b0, rel[4:0]} < width)) begin
          st_d.sdo = tx_empty ? 1'b0 : aligned[5'd31 - rel[4:0]];
          // Mono repeats the left sample in the right slot.
          if (({1'b0, rel[4:0]} == width - 6'h01) && (stereo || rel[5])) begin
            tx_pop = !tx_empty;
          end
        end
      end else begin
        // Rising bit clock: capture one input bit.
        rel = st_q.bitcnt - offset;
        if (in_en && ({1'b0, rel[4:0]} < width)) begin
          buf_new[5'd31 - rel[4:0]] = audio_serial_in;
          st_d.rxbuf = buf_new;
          // Mono keeps only the left slot.
          if (({1'b0, rel[4:0]} == width - 6'h01) && (stereo || !rel[5])) begin
            rx_push = 1'b1;
            rx_word = buf_new >> (6'h20 - width);
          end
        end
      end
    end

    // A disabled output path pulls the line low at once, not at the next bit edge.
    if (!out_en) begin
      st_d.sdo = 1'b0;
    end

    // Frame timing measurement and once-per-frame decisions.
    if (sof) begin
      // The marker cycle itself counts, so a period of N cycles measures as N.
      st_d.sof_cnt = 20'h1;
      st_d.sof_num = st_q.sof_num + 4'h1;
      st_d.sof_sum = st_q.sof_sum + {4'h0, st_q.sof_cnt};
      // Packet size for the coming input packet from input fill.
      st_d.pkt_valid = 1'b1;
      if (rx_level > st_q.marks[`AUD_MARK_IN_HIGH +: 5]) begin
        st_d.pkt_bytes = st_q.pkts[`AUD_PKT_LARGE +: 8];
      end else if (rx_level < st_q.marks[`AUD_MARK_IN_LOW +: 5]) begin
        st_d.pkt_bytes = st_q.pkts[`AUD_PKT_SMALL +: 8];
      end else begin
        st_d.pkt_bytes = st_q.pkts[`AUD_PKT_NORMAL +: 8];
      end
      // Adaptive trim from output fill.
      if (mode == MODE_ADAPTIVE) begin
        if (tx_level > st_q.marks[`AUD_MARK_OUT_HIGH +: 5]) begin
          st_d.inc = st_q.inc + {16'h0, st_q.step};
        end else if (tx_level < st_q.marks[`AUD_MARK_OUT_LOW +: 5]) begin
          st_d.inc = st_q.inc - {16'h0, st_q.step};
        end
      end
      // Sixteen frames complete a measurement window.
      if (st_q.sof_num == 4'hf) begin
        st_d.sof_meas = st_d.sof_sum;
        st_d.sof_sum = '0;
        if (mode == MODE_SOF_LOCKED) begin
          // A longer window means a slower host clock.
          if (st_d.sof_sum > window_nominal) begin
            st_d.inc = st_q.inc - {16'h0, st_q.step};
          end else if (st_d.sof_sum < window_nominal) begin
            st_d.inc = st_q.inc + {16'h0, st_q.step};
          end
        end
      end
    end else if (st_q.sof_cnt != 20'hfffff) begin
      st_d.sof_cnt = st_q.sof_cnt + 20'h1;
    end

    // Plug detect: a change sets a sticky flag, reporting is gated.
    st_d.mic_prev = mic_plug_detect;
    st_d.jack_rep = st_q.ctrl[`AUD_CTRL_JACK_EN] && mic_plug_detect;
    st_d.fast = st_q.ctrl[`AUD_CTRL_FAST];
    st_d.sdo_oe = out_en;

    // Register slave: take a request, answer one cycle later.
    case (st_q.bus)
      BUS_IDLE: begin
        if ((avs_read || avs_write) && !(avs_write && avs_address == `AUD_TXDATA_OFS && tx_full)) begin
          st_d.bus = BUS_ANSWER;
          st_d.waitreq = 1'b0;
          st_d.rdata = '0;
          if (avs_write) begin
            case (avs_address)
              `AUD_CTRL_OFS: begin
                st_d.ctrl = be_merge(st_q.ctrl, avs_writedata, avs_byteenable);
                st_d.inc = rate_inc(st_d.ctrl[`AUD_CTRL_RATE +: 4]);
              end
              `AUD_STATUS_OFS: begin
                if (avs_byteenable[2] && avs_writedata[`AUD_STAT_JACK_EVT]) begin
                  st_d.jack_evt = 1'b0;
                end
              end
              `AUD_MARKS_OFS: st_d.marks = be_merge(st_q.marks, avs_writedata, avs_byteenable);
              `AUD_PKTS_OFS: st_d.pkts = be_merge(st_q.pkts, avs_writedata, avs_byteenable);
              `AUD_STEP_OFS: st_d.step = 16'(be_merge({16'h0, st_q.step}, avs_writedata, avs_byteenable));
              `AUD_TXDATA_OFS: tx_push = 1'b1;
              default: begin
              end
            endcase
          end else begin
            case (avs_address)
              `AUD_CTRL_OFS: st_d.rdata = st_q.ctrl;
              `AUD_STATUS_OFS: begin
                st_d.rdata[`AUD_STAT_IN_LVL +: 5] = rx_level;
                st_d.rdata[`AUD_STAT_OUT_LVL +: 5] = tx_level;
                st_d.rdata[`AUD_STAT_MIC] = mic_plug_detect;
                st_d.rdata[`AUD_STAT_JACK_EVT] = st_q.jack_evt;
              end
              `AUD_MARKS_OFS: st_d.rdata = st_q.marks;
              `AUD_PKTS_OFS: st_d.rdata = st_q.pkts;
              `AUD_STEP_OFS: st_d.rdata = {16'h0, st_q.step};
              `AUD_INC_OFS: st_d.rdata = st_q.inc;
              `AUD_RXDATA_OFS: begin
                st_d.rdata = rx_empty ? 32'h0000_0000 : rx_head;
                rx_pop = 1'b1;
              end
              `AUD_PKTSEL_OFS: st_d.rdata = {24'h0, st_q.pkt_bytes};
              `AUD_SOFMEAS_OFS: st_d.rdata = {8'h0, st_q.sof_meas};
              default: st_d.rdata = '0;
            endcase
          end
        end
      end
      BUS_ANSWER: begin
        st_d.bus = BUS_IDLE;
        st_d.waitreq = 1'b1;
      end
      default: begin
        st_d.bus = BUS_IDLE;
        st_d.waitreq = 1'b1;
      end
    endcase

    // A plug change wins over a clear in the same cycle.
    if (mic_plug_detect != st_q.mic_prev) begin
      st_d.jack_evt = 1'b1;
    end
    // Fixed mode keeps the nominal rate whatever else happened.
    if (mode == MODE_FIXED) begin
      st_d.inc = rate_inc(st_d.ctrl[`AUD_CTRL_RATE +: 4]);
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.bus <= BUS_IDLE;
      st_q.waitreq <= 1'b1;
      st_q.ctrl <= `AUD_CTRL_RST;
      st_q.marks <= `AUD_MARKS_RST;
      st_q.pkts <= `AUD_PKTS_RST;
      st_q.step <= `AUD_STEP_RST;
      st_q.inc <= rate_inc(4'h8);
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register.
  assign avs_readdata = st_q.rdata;
  assign avs_waitrequest = st_q.waitreq;
  assign in_packet_bytes = st_q.pkt_bytes;
  assign in_packet_valid = st_q.pkt_valid;
  assign audio_master_clock = st_q.mclk;
  assign audio_bit_clock = st_q.sck;
  assign audio_word_select = st_q.ws;
  assign audio_serial_out = st_q.sdo;
  assign audio_serial_out_oe = st_q.sdo_oe;
  assign jack_report = st_q.jack_rep;
  assign ctl_link_fast = st_q.fast;

  // Word select rises only after the last bit of the left slot.
  property p_ws_slot;
    @(posedge clk) disable iff (rst)
      $rose(audio_word_select) |-> ($past(st_q.bitcnt) == 6'h1f) && $fell(audio_bit_clock);
  endproperty
  a_ws_slot: assert property (p_ws_slot) else $error("word select edge off slot");

  // Master clock toggles together with the bit clock.
  property p_mclk_edge;
    @(posedge clk) disable iff (rst)
      $changed(audio_bit_clock) |-> $changed(audio_master_clock);
  endproperty
  a_mclk_edge: assert property (p_mclk_edge) else $error("master clock out of step");

  // The output pin is released while the output path is off.
  property p_out_release;
    @(posedge clk) disable iff (rst)
      (!out_en && !(avs_write && st_q.bus == BUS_IDLE)) |=> !audio_serial_out_oe && !audio_serial_out;
  endproperty
  a_out_release: assert property (p_out_release) else $error("output driven while disabled");

  // A frame marker with input fill above the high mark yields the large packet size.
  sequence s_frame_start;
    sof ##0 (rx_level > st_q.marks[`AUD_MARK_IN_HIGH +: 5]);
  endsequence
  property p_pkt_large;
    @(posedge clk) disable iff (rst)
      s_frame_start |=> in_packet_valid && (in_packet_bytes == $past(st_q.pkts[`AUD_PKT_LARGE +: 8]));
  endproperty
  a_pkt_large: assert property (p_pkt_large) else $error("large packet not chosen");

  // Fixed mode always runs at the nominal step.
  property p_fixed_rate;
    @(posedge clk) disable iff (rst)
      (mode == MODE_FIXED) |=> (st_q.inc == rate_inc($past(st_d.ctrl[`AUD_CTRL_RATE +: 4])));
  endproperty
  a_fixed_rate: assert property (p_fixed_rate) else $error("fixed rate drifted");

  // Adaptive mode raises the rate by one step when the output FIFO is high.
  property p_adapt_up;
    @(posedge clk) disable iff (rst)
      (sof && mode == MODE_ADAPTIVE && tx_level > st_q.marks[`AUD_MARK_OUT_HIGH +: 5] && !avs_write)
        |=> (st_q.inc == $past(st_q.inc) + {16'h0, $past(st_q.step)});
  endproperty
  a_adapt_up: assert property (p_adapt_up) else $error("adaptive raise missing");

  // Between frame markers the adaptive rate holds.
  property p_adapt_hold;
    @(posedge clk) disable iff (rst)
      (!sof && mode == MODE_ADAPTIVE && !avs_write) |=> $stable(st_q.inc);
  endproperty
  a_adapt_hold: assert property (p_adapt_hold) else $error("rate changed between frames");

  // With reporting disabled no plug is reported.
  property p_jack_gate;
    @(posedge clk) disable iff (rst)
      !st_q.ctrl[`AUD_CTRL_JACK_EN] |=> !jack_report;
  endproperty
  a_jack_gate: assert property (p_jack_gate) else $error("plug reported while disabled");

  // With both paths off the link clocks stand still low.
  property p_link_idle;
    @(posedge clk) disable iff (rst)
      (!out_en && !in_en) |=> !audio_bit_clock && !audio_word_select;
  endproperty
  a_link_idle: assert property (p_link_idle) else $error("link clocks run while disabled");
endmodule

// ===== test/codec_model.sv
// Behavioural codec that sends a fixed sample pattern into the bridge.
`timescale 1ns/1ps
module codec_model (
  // Serial clocks from the bridge.
  input wire logic bit_clock,
  input wire logic word_select,
  // Data toward the bridge.
  output logic serial_in,
  // Data from the bridge, the last 16-bit sample heard and the last bit position of a slot.
  input wire logic serial_out,
  output logic [15:0] heard,
  output logic [5:0] slot_last
);
  // Sample sent in every slot, most significant bit first.
  logic [31:0] pattern_q = 32'hc3a5_0f81;
  // Word select seen at the last falling bit clock.
  logic ws_last_q = 1'b0;
  // Bit position within the current slot.
  int bit_q = 0;
  // Line toward the bridge, output shift register, last sample and last slot end.
  logic sin_q = 1'b0;
  logic [15:0] shift_q = 16'h0000;
  logic [15:0] heard_q = 16'h0000;
  logic [5:0] last_q = 6'h00;
  assign serial_in = sin_q;
  assign heard = heard_q;
  assign slot_last = last_q;
  // Data changes on the falling bit clock; I2S framing puts the MSB one bit after the slot edge.
  always @(negedge bit_clock) begin
    if (word_select !== ws_last_q) begin
      last_q = 6'(bit_q);
      bit_q = 0;
    end else begin
      bit_q = bit_q + 1;
    end
    ws_last_q = word_select;
    // Outside the sample bits the line toggles so that no stale value looks valid.
    sin_q = (bit_q >= 1 && bit_q <= 32) ? pattern_q[32 - bit_q] : ~sin_q;
  end
  // The bridge's output is read on the rising bit clock, 16 bits from one bit after the slot edge.
  always @(posedge bit_clock) begin
    if (bit_q >= 1 && bit_q <= 16) begin
      shift_q = {shift_q[14:0], serial_out};
      if (bit_q == 16) begin
        heard_q = shift_q;
      end
    end
  end
endmodule

// ===== test/usb_audio_serial_bridge_test.sv
// Self-checking testbench of the audio serial bridge.
`timescale 1ns/1ps
`include "audio_bridge_regs.svh"
module usb_audio_serial_bridge_test;
  logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, sof = 1'b0, mic_plug_detect = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, in_packet_valid, mclk, bclk, ws, sdo, sdo_oe, sdi, jack_report, ctl_link_fast;
  logic [7:0] in_packet_bytes;
  int n_errors = 0, n_checks = 0, n, w, nm;
  logic [31:0] inc0;
  logic [15:0] heard;
  logic [5:0] slot_last;
  // Reset table rows: address and the value a read must return.
  logic [5:0] row_a[6] = '{`AUD_CTRL_OFS, `AUD_MARKS_OFS, `AUD_PKTS_OFS, `AUD_STEP_OFS, 6'h28, 6'h02};
  logic [31:0] row_v[6] = '{32'h0000_41c3, 32'h0c04_0c04, 32'h00c4_c0bc, 32'h0000_0100, 32'h0, 32'h0};

  usb_audio_serial_bridge #(.SOF_NOMINAL_CYCLES(200)) DUT (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sof(sof), .in_packet_bytes(in_packet_bytes),
    .in_packet_valid(in_packet_valid), .audio_master_clock(mclk), .audio_bit_clock(bclk),
    .audio_word_select(ws), .audio_serial_out(sdo), .audio_serial_out_oe(sdo_oe), .audio_serial_in(sdi),
    .mic_plug_detect(mic_plug_detect), .jack_report(jack_report), .ctl_link_fast(ctl_link_fast));
  codec_model codec (.bit_clock(bclk), .word_select(ws), .serial_in(sdi), .serial_out(sdo), .heard(heard),
    .slot_last(slot_last));

  // Clock at 25 MHz.
  initial forever #20 clk = ~clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int k;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      n_errors++;
      report_and_stop();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  // One frame start marker and the packet size that must follow it.
  task automatic frame(input logic [7:0] exp);
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
    @(posedge clk);
    check("packet valid", {31'h0, in_packet_valid}, 32'h1);
    check("packet bytes", {24'h0, in_packet_bytes}, {24'h0, exp});
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values and unmapped places.
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, row_a[i], 32'h0);
      check("reset row", rd, row_v[i]);
    end
    check("oe after reset", {31'h0, sdo_oe}, 32'h1);
    frame(8'hbc);
    $display("test reset done");
    // Input FIFO fills from the codec until it is full, past the high mark.
    n = 0;
    do begin
      bus(1'b0, `AUD_STATUS_OFS, 32'h0);
      n++;
    end while (rd[4:0] !== 5'h10 && n < 3000);
    if (n >= 3000) begin
      n_errors++;
      report_and_stop();
    end
    frame(8'hc4);
    repeat (3) bus(1'b0, `AUD_RXDATA_OFS, 32'h0);
    check("captured sample", rd, 32'h0000_c3a5);
    $display("test capture done");
    // Plug report follows the detect line only while enabled; the change flag sticks until cleared.
    mic_plug_detect <= 1'b1;
    repeat (3) @(posedge clk);
    check("jack report on", {31'h0, jack_report}, 32'h1);
    bus(1'b0, `AUD_STATUS_OFS, 32'h0);
    check("mic status", {31'h0, rd[16]}, 32'h1);
    check("jack change", {31'h0, rd[17]}, 32'h1);
    bus(1'b1, `AUD_STATUS_OFS, 32'h0002_0000);
    bus(1'b0, `AUD_STATUS_OFS, 32'h0);
    check("jack change cleared", {31'h0, rd[17]}, 32'h0);
    bus(1'b1, `AUD_CTRL_OFS, 32'h0000_4542);
    repeat (2) @(posedge clk);
    check("jack report off", {31'h0, jack_report}, 32'h0);
    check("fast link", {31'h0, ctl_link_fast}, 32'h1);
    check("oe off", {31'h0, sdo_oe}, 32'h0);
    // Output only, adaptive; the input FIFO is drained to between its marks.
    bus(1'b1, `AUD_CTRL_OFS, 32'h0000_4141);
    check("oe on", {31'h0, sdo_oe}, 32'h1);
    repeat (6) bus(1'b0, `AUD_RXDATA_OFS, 32'h0);
    bus(1'b0, `AUD_INC_OFS, 32'h0);
    inc0 = rd;
    // The host hands over the same number of samples every frame; the second frame finds the FIFO high.
    for (int i = 0; i < 2; i++) begin
      repeat (8) bus(1'b1, `AUD_TXDATA_OFS, 32'h0000_5a3c);
      frame(8'hc0);
      bus(1'b0, `AUD_INC_OFS, 32'h0);
      check("adaptive rate", rd, inc0 + ((i == 1) ? 32'h0000_0100 : 32'h0000_0000));
    end
    // The codec must hear the sample; the master clock runs in step with the bit clock.
    w = 0;
    nm = 0;
    while (heard !== 16'h5a3c && w < 2000) begin
      @(posedge clk);
      nm += (mclk !== bclk);
      w++;
    end
    if (w >= 2000) begin
      n_errors++;
      report_and_stop();
    end
    check("serial out", {16'h0, heard}, 32'h0000_5a3c);
    check("slot length", {26'h0, slot_last}, 32'h0000_001f);
    check("master clock", nm, 32'h0);
    // Fixed mode ignores the fill of the output FIFO.
    bus(1'b1, `AUD_CTRL_OFS, 32'h0000_4041);
    frame(8'hc0);
    bus(1'b0, `AUD_INC_OFS, 32'h0);
    check("fixed rate", rd, inc0);
    $display("test output done");
    // Both paths off: the bit clock stays low.
    bus(1'b1, `AUD_CTRL_OFS, 32'h0000_4140);
    repeat (4) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      check("bit clock idle", {31'h0, bclk}, 32'h0);
    end
    $display("test control done");
    report_and_stop();
  end
endmodule
